// file: seal_defs.vh
// Constants for the serial EEPROM autoloader: offsets, fields, timing.
// Assumes a 100 MHz core clock and a two-wire memory strapped at address 0.
`ifndef SEAL_DEFS_VH
`define SEAL_DEFS_VH

// Timing
`define SEAL_CLK_NS 10
`define SEAL_SCL_PERIOD_NS 10000
`define SEAL_QTR_CYC ((`SEAL_SCL_PERIOD_NS / 4 + `SEAL_CLK_NS - 1) / `SEAL_CLK_NS)
`define SEAL_TWR_NS 5000000
`define SEAL_TWR_CYC ((`SEAL_TWR_NS + `SEAL_CLK_NS - 1) / `SEAL_CLK_NS)

// Register byte addresses; the word window is given as paddr[11:6]
`define SEAL_OFS_CTRL 12'h0d4
`define SEAL_OFS_DATA 12'h0d8
`define SEAL_OFS_STATUS 12'h0dc
`define SEAL_OFS_WORDS 6'h04

// Status fields
`define SEAL_STAT_BUSY 0
`define SEAL_STAT_ERR 1
`define SEAL_STAT_SIG 2
`define SEAL_STAT_AUTO 3

// Control fields
`define SEAL_CTRL_START 0
`define SEAL_CTRL_WR 1
`define SEAL_CTRL_ADDR_LSB 8
`define SEAL_CTRL_ADDR_MSB 14

// Memory layout
`define SEAL_WORDS 16
`define SEAL_SIG_DEFAULT 16'h5a5a
`define SEAL_DEV_WR 8'ha0
`define SEAL_DEV_RD 8'ha1
`define SEAL_W_LINK 3
`define SEAL_W_CAP 6
`define SEAL_W_MARGIN 7
`define SEAL_W_PHY5LO 13
`define SEAL_W_PHY5HI 14
`define SEAL_W_LAST 7'h0e

// Byte engine commands
`define SEAL_CMD_START 2'h0
`define SEAL_CMD_STOP 2'h1
`define SEAL_CMD_WRITE 2'h2
`define SEAL_CMD_READ 2'h3

`endif

// file: seal_sync.v
// Two-flop synchroniser for one level from outside the core clock domain.
// Resets to the idle-high level of the serial data line.
`timescale 1ns/100ps
`default_nettype none

module seal_sync (
  input wire clk,
  input wire rst,
  input wire async_in,
  output wire sync_out
);

reg meta_q;
reg sync_q;

always @(posedge clk)
begin
  if (rst)
  begin
    meta_q <= 1'b1;
    sync_q <= 1'b1;
  end
  else
  begin
    meta_q <= async_in;
    sync_q <= meta_q;
  end
end

assign sync_out = sync_q;

endmodule // seal_sync

`default_nettype wire

// file: seal_byte.v
// Two-wire bit engine: start, stop, byte write with ack, byte read.
// Assumes a synchronised data input; clock is derived by a quarter divider.
`timescale 1ns/100ps
`default_nettype none
`include "seal_defs.vh"

module seal_byte #(
  parameter [15:0] QTR_CYC = `SEAL_QTR_CYC
) (
  input wire clk,
  input wire rst,
  input wire go,
  input wire [1:0] cmd,
  input wire [7:0] tx_byte,
  input wire nack_last,
  input wire sda_in,
  output wire busy,
  output wire done,
  output wire [7:0] rx_byte,
  output wire ack_ok,
  output wire scl,
  output wire sda_low
);

reg busy_q;
reg done_q;
reg ack_q;
reg scl_q;
reg low_q;
reg nack_q;
reg [1:0] cmd_q;
reg [1:0] qtr_q;
reg [3:0] bit_q;
reg [7:0] sh_q;
reg [15:0] div_q;
reg scl_d;
reg low_d;

wire tick = busy_q && (div_q == (QTR_CYC - 16'h0001));
wire mid = (qtr_q == 2'h1) || (qtr_q == 2'h2);
wire last_bit = (bit_q == 4'h8);
wire tx_bit = last_bit ? ((cmd_q == `SEAL_CMD_WRITE) | nack_q)
                       : ((cmd_q == `SEAL_CMD_READ) | sh_q[7]);

////////////////////////////////////////////////////////////////////////
// Line levels per quarter
always @*
begin
  case (cmd_q)
    `SEAL_CMD_START:
    begin
      scl_d = mid;
      low_d = qtr_q[1];
    end
    `SEAL_CMD_STOP:
    begin
      scl_d = (qtr_q != 2'h0);
      low_d = !qtr_q[1];
    end
    default:
    begin
      scl_d = mid;
      low_d = !tx_bit;
    end
  endcase
end

////////////////////////////////////////////////////////////////////////
// Quarter sequencing
always @(posedge clk)
begin
  if (rst)
  begin
    busy_q <= 1'b0;
    done_q <= 1'b0;
    ack_q <= 1'b0;
    scl_q <= 1'b1;
    low_q <= 1'b0;
    nack_q <= 1'b0;
    cmd_q <= `SEAL_CMD_STOP;
    qtr_q <= 2'h0;
    bit_q <= 4'h0;
    sh_q <= 8'h00;
    div_q <= 16'h0000;
  end
  else
  begin
    done_q <= 1'b0;
    if (!busy_q)
    begin
      div_q <= 16'h0000;
      if (go)
      begin
        busy_q <= 1'b1;
        cmd_q <= cmd;
        sh_q <= tx_byte;
        nack_q <= nack_last;
        qtr_q <= 2'h0;
        bit_q <= 4'h0;
      end
    end
    else
    begin
      div_q <= tick ? 16'h0000 : div_q + 16'h0001;
      if (tick)
      begin
        scl_q <= scl_d;
        low_q <= low_d;
        qtr_q <= qtr_q + 2'h1;
        if (qtr_q == 2'h3)
        begin
          // Sample while clock still high, shift on the same edge that drops it
          if (cmd_q[1] && last_bit)
            ack_q <= !sda_in;
          else if (cmd_q[1])
            sh_q <= {sh_q[6:0], sda_in};
          if (!cmd_q[1] || last_bit)
          begin
            busy_q <= 1'b0;
            done_q <= 1'b1;
          end
          else
            bit_q <= bit_q + 4'h1;
        end
      end
    end
  end
end

assign busy = busy_q;
assign done = done_q;
assign rx_byte = sh_q;
assign ack_ok = ack_q;
assign scl = scl_q;
assign sda_low = low_q;

endmodule // seal_byte

`default_nettype wire

// file: seal_top.v
// Serial EEPROM autoloader: APB registers, word sequencer, loaded words.
// Assumes an APB master on clk and a two-wire memory with select pins low.
`timescale 1ns/100ps
`default_nettype none
`include "seal_defs.vh"

module seal_top #(
  parameter [15:0] QTR_CYC = `SEAL_QTR_CYC,
  parameter [15:0] SIGNATURE = `SEAL_SIG_DEFAULT,
  parameter [23:0] TWR_CYC = `SEAL_TWR_CYC
) (
  input wire clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  output wire serial_mem_clock,
  input wire serial_mem_data_in,
  output wire serial_mem_data_out,
  output wire serial_mem_data_oe,
  output wire autoload_busy,
  output wire [15:0] cfg_link_word,
  output wire [15:0] cfg_cap_word,
  output wire [15:0] cfg_tx_margin,
  output wire [4:0] cfg_buffer_tuning,
  output wire [23:0] phy_tuning_word5
);

localparam [11:0] S_IDLE = 12'h001;
localparam [11:0] S_STA = 12'h002;
localparam [11:0] S_DEVW = 12'h004;
localparam [11:0] S_ADDR = 12'h008;
localparam [11:0] S_RSTA = 12'h010;
localparam [11:0] S_DEVR = 12'h020;
localparam [11:0] S_RDLO = 12'h040;
localparam [11:0] S_RDHI = 12'h080;
localparam [11:0] S_WRLO = 12'h100;
localparam [11:0] S_WRHI = 12'h200;
localparam [11:0] S_STOP = 12'h400;
localparam [11:0] S_TWR = 12'h800;

reg [11:0] state_q;
reg [11:0] nxt;
reg issued_q;
reg auto_q;
reg sig_ok_q;
reg err_q;
reg failed_q;
reg op_wr_q;
reg [6:0] waddr_q;
reg [15:0] wdata_q;
reg [15:0] rdata_q;
reg ctrl_wr_q;
reg [6:0] caddr_q;
reg [23:0] twr_q;
reg [31:0] prdata_q;
reg pslverr_q;
reg [15:0] words_q [0:`SEAL_WORDS-1];
reg [1:0] eng_cmd;
reg [7:0] eng_tx;
reg eng_nack;
reg [31:0] rd_d;
reg bad_d;
integer i;

wire sda_sync;
wire eng_busy;
wire eng_done;
wire [7:0] eng_rx;
wire eng_ack;
wire eng_low;
wire active = !state_q[0] && (state_q != S_TWR);
wire eng_go = active && !issued_q && !eng_busy;
wire is_wr_state = (state_q == S_DEVW) || (state_q == S_ADDR) || (state_q == S_DEVR)
                   || (state_q == S_WRLO) || (state_q == S_WRHI);
wire apb_wr = psel && penable && pwrite;
wire wr_ctrl = apb_wr && (paddr == `SEAL_OFS_CTRL);
wire wr_data = apb_wr && (paddr == `SEAL_OFS_DATA);
wire wr_stat = apb_wr && (paddr == `SEAL_OFS_STATUS);
wire sw_start = wr_ctrl && pwdata[`SEAL_CTRL_START];
wire err_clr = wr_stat && pwdata[`SEAL_STAT_ERR];
wire err_set = eng_done && is_wr_state && !eng_ack;
wire seq_busy = !state_q[0];

////////////////////////////////////////////////////////////////////////
// Line interface
seal_sync u_sync (
  .clk(clk),
  .rst(rst),
  .async_in(serial_mem_data_in),
  .sync_out(sda_sync)
);

seal_byte #(
  .QTR_CYC(QTR_CYC)
) u_byte (
  .clk(clk),
  .rst(rst),
  .go(eng_go),
  .cmd(eng_cmd),
  .tx_byte(eng_tx),
  .nack_last(eng_nack),
  .sda_in(sda_sync),
  .busy(eng_busy),
  .done(eng_done),
  .rx_byte(eng_rx),
  .ack_ok(eng_ack),
  .scl(serial_mem_clock),
  .sda_low(eng_low)
);

// Open-drain: only ever pull low
assign serial_mem_data_out = 1'b0;
assign serial_mem_data_oe = eng_low;

////////////////////////////////////////////////////////////////////////
// Byte to send and next step for each state
always @*
begin
  eng_cmd = `SEAL_CMD_WRITE;
  eng_tx = 8'h00;
  eng_nack = 1'b0;
  nxt = S_IDLE;
  case (state_q)
    S_STA:
    begin
      eng_cmd = `SEAL_CMD_START;
      nxt = S_DEVW;
    end
    S_DEVW:
    begin
      eng_tx = `SEAL_DEV_WR;
      nxt = S_ADDR;
    end
    S_ADDR:
    begin
      eng_tx = {waddr_q, 1'b0};
      nxt = op_wr_q ? S_WRLO : S_RSTA;
    end
    S_RSTA:
    begin
      eng_cmd = `SEAL_CMD_START;
      nxt = S_DEVR;
    end
    S_DEVR:
    begin
      eng_tx = `SEAL_DEV_RD;
      nxt = S_RDLO;
    end
    S_RDLO:
    begin
      eng_cmd = `SEAL_CMD_READ;
      nxt = S_RDHI;
    end
    S_RDHI:
    begin
      eng_cmd = `SEAL_CMD_READ;
      eng_nack = 1'b1;
      nxt = S_STOP;
    end
    S_WRLO:
    begin
      eng_tx = wdata_q[7:0];
      nxt = S_WRHI;
    end
    S_WRHI:
    begin
      eng_tx = wdata_q[15:8];
      nxt = S_STOP;
    end
    S_STOP:
    begin
      eng_cmd = `SEAL_CMD_STOP;
      nxt = op_wr_q ? S_TWR : S_IDLE;
    end
    default:
    begin
      nxt = S_IDLE;
    end
  endcase
end

////////////////////////////////////////////////////////////////////////
// Word sequencer and autoload
always @(posedge clk)
begin
  if (rst)
  begin
    state_q <= S_IDLE;
    issued_q <= 1'b0;
    auto_q <= 1'b1;
    sig_ok_q <= 1'b0;
    failed_q <= 1'b0;
    op_wr_q <= 1'b0;
    waddr_q <= 7'h00;
    rdata_q <= 16'h0000;
    twr_q <= 24'h00_0000;
  end
  else
  begin
    case (state_q)
      S_IDLE:
      begin
        failed_q <= 1'b0;
        if (auto_q)
        begin
          op_wr_q <= 1'b0;
          state_q <= S_STA;
        end
        else if (sw_start)
        begin
          op_wr_q <= pwdata[`SEAL_CTRL_WR];
          waddr_q <= pwdata[`SEAL_CTRL_ADDR_MSB:`SEAL_CTRL_ADDR_LSB];
          state_q <= S_STA;
        end
      end
      S_TWR:
      begin
        // Memory internal write time before the next access
        if (twr_q >= TWR_CYC - 24'h00_0001)
        begin
          twr_q <= 24'h00_0000;
          state_q <= S_IDLE;
        end
        else
          twr_q <= twr_q + 24'h00_0001;
      end
      default:
      begin
        if (eng_go)
          issued_q <= 1'b1;
        if (eng_done)
        begin
          issued_q <= 1'b0;
          if (state_q == S_RDLO)
            rdata_q[7:0] <= eng_rx;
          if (state_q == S_RDHI)
            rdata_q[15:8] <= eng_rx;
          if (err_set)
          begin
            failed_q <= 1'b1;
            state_q <= S_STOP;
          end
          else
            state_q <= nxt;
          if ((state_q == S_STOP) && auto_q)
          begin
            if (failed_q)
              auto_q <= 1'b0;
            else if ((waddr_q == 7'h00) && (rdata_q != SIGNATURE))
              auto_q <= 1'b0;
            else if (waddr_q == `SEAL_W_LAST)
              auto_q <= 1'b0;
            else
              waddr_q <= waddr_q + 7'h01;
            if (!failed_q && (waddr_q == 7'h00) && (rdata_q == SIGNATURE))
              sig_ok_q <= 1'b1;
          end
        end
      end
    endcase
  end
end

////////////////////////////////////////////////////////////////////////
// Loaded words
always @(posedge clk)
begin
  if (rst)
  begin
    for (i = 0; i < `SEAL_WORDS; i = i + 1)
      words_q[i] <= 16'h0000;
  end
  else if (eng_done && (state_q == S_STOP) && auto_q && !failed_q
           && ((waddr_q != 7'h00) || (rdata_q == SIGNATURE)))
    words_q[waddr_q[3:0]] <= rdata_q;
end

assign cfg_link_word = words_q[`SEAL_W_LINK];
assign cfg_cap_word = words_q[`SEAL_W_CAP];
assign cfg_tx_margin = words_q[`SEAL_W_MARGIN];
assign cfg_buffer_tuning = words_q[`SEAL_W_PHY5HI][4:0];
assign phy_tuning_word5 = {words_q[`SEAL_W_PHY5HI][15:8], words_q[`SEAL_W_PHY5LO]};
assign autoload_busy = auto_q;

////////////////////////////////////////////////////////////////////////
// APB registers
always @(posedge clk)
begin
  if (rst)
  begin
    err_q <= 1'b0;
    ctrl_wr_q <= 1'b0;
    caddr_q <= 7'h00;
    wdata_q <= 16'h0000;
  end
  else
  begin
    err_q <= (err_q && !err_clr) || err_set;
    if (wr_ctrl)
    begin
      ctrl_wr_q <= pwdata[`SEAL_CTRL_WR];
      caddr_q <= pwdata[`SEAL_CTRL_ADDR_MSB:`SEAL_CTRL_ADDR_LSB];
    end
    if (wr_data && !seq_busy)
      wdata_q <= pwdata[15:0];
  end
end

always @*
begin
  rd_d = 32'h0000_0000;
  bad_d = 1'b0;
  if (paddr == `SEAL_OFS_CTRL)
  begin
    rd_d[`SEAL_CTRL_START] = seq_busy;
    rd_d[`SEAL_CTRL_WR] = ctrl_wr_q;
    rd_d[`SEAL_CTRL_ADDR_MSB:`SEAL_CTRL_ADDR_LSB] = caddr_q;
  end
  else if (paddr == `SEAL_OFS_DATA)
    rd_d = {rdata_q, wdata_q};
  else if (paddr == `SEAL_OFS_STATUS)
  begin
    rd_d[`SEAL_STAT_BUSY] = seq_busy;
    rd_d[`SEAL_STAT_ERR] = err_q;
    rd_d[`SEAL_STAT_SIG] = sig_ok_q;
    rd_d[`SEAL_STAT_AUTO] = auto_q;
  end
  else if ((paddr[11:6] == `SEAL_OFS_WORDS) && (paddr[1:0] == 2'h0))
    rd_d[15:0] = words_q[paddr[5:2]];
  else
    bad_d = 1'b1;
end

// Answer registered in the setup cycle, shown in the access cycle
always @(posedge clk)
begin
  if (rst)
  begin
    prdata_q <= 32'h0000_0000;
    pslverr_q <= 1'b0;
  end
  else if (psel && !penable)
  begin
    prdata_q <= pwrite ? 32'h0000_0000 : rd_d;
    pslverr_q <= bad_d;
  end
end

assign prdata = prdata_q;
assign pready = 1'b1;
assign pslverr = psel && penable && pslverr_q;

endmodule // seal_top

`default_nettype wire

// file: seal_top_checker.sv
// Port-level checker for the serial memory autoloader.
// Assumes binding onto seal_top with a quarter period of at least 4 clocks.
`timescale 1ns/100ps
`default_nettype none

module seal_top_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic serial_mem_clock,
  input wire logic serial_mem_data_out,
  input wire logic serial_mem_data_oe,
  input wire logic autoload_busy,
  input wire logic [15:0] cfg_link_word,
  input wire logic [15:0] cfg_tx_margin
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  a_ready_access: assert property (psel && penable |-> pready)
    else $error("pready low in access phase");
  a_err_in_access: assert property (pslverr |-> psel && penable && prdata == 32'h0)
    else $error("error outside access or with data");
  a_data_open_drain: assert property (!serial_mem_data_out)
    else $error("data line driven high");
  a_busy_at_release: assert property ($fell(rst) |-> autoload_busy && serial_mem_clock)
    else $error("autoload not pending at release");
  a_busy_stays_clear: assert property (!autoload_busy |=> !autoload_busy)
    else $error("autoload restarted without reset");
  a_cfg_frozen_idle: assert property (!autoload_busy |=> $stable(cfg_link_word)
    && $stable(cfg_tx_margin))
    else $error("loaded word changed after autoload");
  a_end_after_stop: assert property ($fell(autoload_busy) |->
    serial_mem_clock && !serial_mem_data_oe)
    else $error("autoload ended inside a frame");
  a_clock_quarter: assert property ($changed(serial_mem_clock) |=>
    $stable(serial_mem_clock) [*3])
    else $error("memory clock phase too short");
endmodule // seal_top_checker

bind seal_top seal_top_checker chk (
  .clk(clk),
  .rst(rst),
  .psel(psel),
  .penable(penable),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .serial_mem_clock(serial_mem_clock),
  .serial_mem_data_out(serial_mem_data_out),
  .serial_mem_data_oe(serial_mem_data_oe),
  .autoload_busy(autoload_busy),
  .cfg_link_word(cfg_link_word),
  .cfg_tx_margin(cfg_tx_margin)
);

`default_nettype wire

// file: seal_mem_model.sv
// Behavioural two-wire serial memory, 512 bytes, select pins strapped low.
// Assumes the bench resolves the data line with a pull-up.
`timescale 1ns/100ps
`default_nettype none

module seal_mem_model (
  input wire logic scl,
  input wire logic sda,
  input wire logic absent,
  output logic sda_low
);
  logic [7:0] mem [0:511];
  logic [7:0] sh;
  logic [8:0] ptr;
  logic [2:0] st;
  logic [3:0] bc;
  logic ps;
  logic pd;
  logic rd_q;

  initial
  begin
    st = 3'h0;
    bc = 4'h0;
    ptr = 9'h000;
    sh = 8'h00;
    ps = 1'h1;
    pd = 1'h1;
    sda_low = 1'h0;
  end

  always @(scl or sda)
  begin
    if (scl && ps && sda !== pd)
    begin
      st = sda ? 3'h0 : 3'h1;
      bc = 4'h0;
      sda_low = 1'h0;
    end
    else if (scl && !ps && st != 3'h0)
    begin
      if (bc < 4'h8)
        sh = {sh[6:0], sda};
      else if (st == 3'h4 && sda)
        st = 3'h0;
      bc = bc + 4'h1;
    end
    else if (!scl && ps && st != 3'h0)
    begin
      if (bc == 4'h9)
        bc = 4'h0;
      if (bc == 4'h8)
      begin
        rd_q = (st == 3'h4);
        case (st)
          3'h1: st = (absent || sh[7:1] != 7'h50) ? 3'h0 : (sh[0] ? 3'h4 : 3'h2);
          3'h2:
          begin
            ptr = {1'h0, sh};
            st = 3'h3;
          end
          3'h3:
          begin
            mem[ptr] = sh;
            ptr = ptr + 9'h001;
          end
          default: ptr = ptr + 9'h001;
        endcase
        sda_low = (st != 3'h0) && !rd_q;
      end
      else if (st == 3'h4)
        sda_low = !mem[ptr][3'h7 - bc[2:0]];
      else
        sda_low = 1'h0;
    end
    ps = scl;
    pd = sda;
  end
endmodule // seal_mem_model

`default_nettype wire

// file: serial_eeprom_autoloader_test.sv
// Bench for seal_top: APB tasks, autoload and single-word sequencer runs.
// Assumes seal_mem_model on the two-wire side and a pull-up on data.
`timescale 1ns/100ps
`default_nettype none

module serial_eeprom_autoloader_test;
  logic clk, rst, psel, penable, pwrite, absent, pready, pslverr, er;
  logic mclk, d_out, d_oe, abusy, mem_low;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] link_w, cap_w, margin_w;
  logic [4:0] buf_t;
  logic [23:0] tun5;
  wire sda = !(d_oe || mem_low);
  int mismatches, comparisons;

  seal_top #(.QTR_CYC(16'h0004), .TWR_CYC(24'h00_000a)) uut (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serial_mem_clock(mclk), .serial_mem_data_in(sda),
    .serial_mem_data_out(d_out), .serial_mem_data_oe(d_oe), .autoload_busy(abusy),
    .cfg_link_word(link_w), .cfg_cap_word(cap_w), .cfg_tx_margin(margin_w),
    .cfg_buffer_tuning(buf_t), .phy_tuning_word5(tun5));
  seal_mem_model mem (.scl(mclk), .sda(sda), .absent(absent), .sda_low(mem_low));

  initial
  begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    @(posedge clk);
    while (pready !== 1'h1)
      @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic wait_idle();
    rd = 32'h0000_0001;
    while (rd[0] !== 1'h0)
      apb(1'h0, 12'h0dc, 32'h0);
  endtask

  task automatic do_reset();
    rst <= 1'h1;
    repeat (16) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    while (abusy === 1'h1)
      @(posedge clk);
  endtask

  function automatic logic [15:0] word(input int i);
    return {mem.mem[2 * i + 1], mem.mem[2 * i]};
  endfunction

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #600000;
    mismatches++;
    summarize();
  end

  initial
  begin
    {psel, penable, pwrite, absent} <= 4'h0;
    paddr <= 12'h000;
    pwdata <= 32'h0;
    for (int i = 2; i < 512; i++)
      mem.mem[i] = 8'(i * 37 + 5);
    mem.mem[0] = 8'h5a;
    mem.mem[1] = 8'h5a;
    fork
      do_reset();
      begin
        repeat (18) @(posedge clk);
        apb(1'h0, 12'h0dc, 32'h0);
        chk(rd[3], 1'h1);
        apb(1'h1, 12'h0d4, 32'h0000_0501);
        chk(abusy, 1'h1);
      end
    join
    for (int i = 0; i < 15; i++)
    begin
      apb(1'h0, 12'h100 + 12'(4 * i), 32'h0);
      chk(rd, {16'h0, word(i)});
    end
    chk(link_w, word(3));
    chk(cap_w, word(6));
    chk(margin_w, word(7));
    chk(buf_t, word(14) & 16'h001f);
    chk(tun5, {word(14) >> 8, word(13)});
    apb(1'h0, 12'h0dc, 32'h0);
    chk(rd, 32'h0000_0004);
    apb(1'h1, 12'h0d8, 32'h0000_c3a5);
    apb(1'h1, 12'h0d4, 32'h0000_7f03);
    wait_idle();
    chk({mem.mem[254], mem.mem[255]}, 16'ha5c3);
    mem.mem[254] = 8'h3c;
    apb(1'h1, 12'h0d4, 32'h0000_7f01);
    wait_idle();
    apb(1'h0, 12'h0d8, 32'h0);
    chk(rd[31:16], 16'hc33c);
    apb(1'h0, 12'h0e0, 32'h0);
    chk(er, 1'h1);
    chk(rd, 32'h0000_0000);
    absent <= 1'h1;
    apb(1'h1, 12'h0d4, 32'h0000_0101);
    wait_idle();
    chk(rd[1], 1'h1);
    apb(1'h1, 12'h0dc, 32'h0000_0002);
    apb(1'h0, 12'h0dc, 32'h0);
    chk(rd[1], 1'h0);
    absent <= 1'h0;
    mem.mem[0] = 8'h00;
    do_reset();
    apb(1'h0, 12'h0dc, 32'h0);
    chk(rd[3:2], 2'h0);
    chk(link_w, 16'h0);
    summarize();
  end
endmodule // serial_eeprom_autoloader_test

`default_nettype wire
